// >>> sfl_ctrl.sv
// Serial-loaded fast-lock, power-down and diagnostic control of a synthesizer.
// Assumes all pin inputs are asynchronous to clk_i and are oversampled.
`timescale 1ns/100ps

module sfl_ctrl
  import sfl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Serial programming pins
  input  wire logic       ser_clk_i,
  input  wire logic       ser_data_i,
  input  wire logic       load_strobe_i,
  // Reference and divider monitor inputs
  input  wire logic       ref_in_i,
  input  wire logic       ref_div_i,
  input  wire logic       int_div_i,
  input  wire logic       lock_detect_i,
  // Loop filter switches and charge pump
  output logic            loop_switch_one_o,
  output logic            loop_switch_two_o,
  output logic            loop_switch_three_o,
  output logic [2:0]      pump_current_exp_o,
  output logic            pump_hiz_o,
  // Power-down effects
  output logic            amp_power_down_o,
  output logic            dividers_hold_o,
  output logic            lock_detect_reset_o,
  output logic            ref_buffer_off_o,
  // Modes and events
  output logic            dither_en_o,
  output logic            lock_thresh_10ns_o,
  output logic            pfd_tick_o,
  output logic            hop_start_o,
  output logic            diagnostic_output_pin_o
);

  typedef struct packed {
    logic [SYNC_N-1:0] s0;
    logic [SYNC_N-1:0] s1;
    logic [SYNC_N-1:0] s2;
    logic [SYNC_N-1:0] flt;
    logic [WORD_W-1:0] shift;
    logic              dbl;
    logic              half;
    logic [3:0]        rcnt;
    logic [4:0]        pdiv;
    logic              phase_detector;
    logic [1:0]        qdiv;
    logic              qtick;
    logic [4:0]        pd;
    logic [3:0]        mode;
    logic [3:0]        mux;
    logic              hop_wait;
    logic [4:0]        hop_cnt;
    logic              hop;
    logic              ramp;
    logic [2:0]        pump;
    logic              diag;
  } sfl_state_t;

  sfl_state_t s_q;
  sfl_state_t s_d;

  logic [SYNC_N-1:0] pin_w;
  logic [SYNC_N-1:0] rise_w;
  logic [SYNC_N-1:0] fall_w;
  logic [SYNC_N-1:0] flt_w;
  logic              latch_w;
  logic [2:0]        sel_w;
  logic [1:0]        tsel_w;
  logic [TMO_W-1:0]  tcnt_w;
  logic [2:0]        tload_w;
  logic [2:0]        tact_w;
  logic [2:0]        texp_w;
  logic              ref_edge_w;
  logic [4:0]        pdiv_last_w;
  logic              freq_wr_w;
  logic              pd_amp_hi_w;
  logic              pd_amp_lo_w;
  logic              pd_pump_w;
  logic              pd_cnt_rst_w;
  logic              pd_hiz_w;

  // ----------------------------------------------------------------------
  // Pin sampling: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  assign pin_w  = {lock_detect_i, int_div_i, ref_div_i, ref_in_i,
                   load_strobe_i, ser_data_i, ser_clk_i};
  assign flt_w  = (s_q.s1 & s_q.s2) | (s_q.flt & (s_q.s1 ^ s_q.s2));
  assign rise_w = flt_w & ~s_q.flt;
  assign fall_w = ~flt_w & s_q.flt;

  // ----------------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------------
  assign latch_w   = rise_w[2];
  assign sel_w     = s_q.shift[2:0];
  assign tsel_w    = s_q.shift[TSEL_LSB+1:TSEL_LSB];
  assign tcnt_w    = s_q.shift[TMO_LSB+TMO_W-1:TMO_LSB];
  assign freq_wr_w = latch_w && (sel_w == SEL_FREQ_WORD);

  // ----------------------------------------------------------------------
  // Power-down register fields
  // ----------------------------------------------------------------------
  assign pd_amp_hi_w  = s_q.pd[AMP_PD_HI_BIT-CP_HIZ_BIT];
  assign pd_amp_lo_w  = s_q.pd[AMP_PD_LO_BIT-CP_HIZ_BIT];
  assign pd_pump_w    = s_q.pd[CP_PD_BIT-CP_HIZ_BIT];
  assign pd_cnt_rst_w = s_q.pd[CNT_RST_BIT-CP_HIZ_BIT];
  assign pd_hiz_w     = s_q.pd[CP_HIZ_BIT-CP_HIZ_BIT];

  always_comb begin
    tload_w = 3'h0;
    if (latch_w && (sel_w == SEL_FASTLOCK)) begin
      if (tsel_w == TSEL_PUMP) begin
        tload_w[0] = 1'b1;
      end else if (tsel_w == TSEL_SW3) begin
        tload_w[1] = 1'b1;
      end else if (tsel_w == TSEL_SW12) begin
        tload_w[2] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reference divider: doubler counts both edges, halver doubles the count
  // ----------------------------------------------------------------------
  assign ref_edge_w  = rise_w[3] || (s_q.dbl && fall_w[3]);
  assign pdiv_last_w = ({1'b0, ((s_q.rcnt == 4'h0) ? 4'h1 : s_q.rcnt)}
                        << s_q.half) - 5'h1;

  // ----------------------------------------------------------------------
  // Timeout counters: pump current, switch three, switches one and two
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_tmo
    sfl_timeout u_tmo (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .load_i    (tload_w[i]),
      .count_i   (tcnt_w),
      .start_i   (s_q.hop),
      .tick_i    (s_q.qtick),
      .active_o  (tact_w[i]),
      .expired_o (texp_w[i])
    );
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.s0    = pin_w;
    s_d.s1    = s_q.s0;
    s_d.s2    = s_q.s1;
    s_d.flt   = flt_w;
    s_d.phase_detector   = 1'b0;
    s_d.qtick = 1'b0;
    s_d.hop   = 1'b0;

    // Shift in on the serial clock rising edge, most significant bit first
    if (rise_w[0]) begin
      s_d.shift = {s_q.shift[WORD_W-2:0], flt_w[1]};
    end

    // Register latch on the load strobe rising edge
    if (latch_w) begin
      if (sel_w == SEL_DIV_SETUP) begin
        s_d.dbl  = s_q.shift[DBL_BIT];
        s_d.half = s_q.shift[HALF_BIT];
        s_d.rcnt = s_q.shift[RCNT_LSB+3:RCNT_LSB];
      end else if (sel_w == SEL_POWER_DOWN) begin
        s_d.pd = s_q.shift[AMP_PD_HI_BIT:CP_HIZ_BIT];
      end else if (sel_w == SEL_DIAG_MODES) begin
        s_d.mode = s_q.shift[MODE_LSB+3:MODE_LSB];
        s_d.mux  = s_q.shift[MUX_LSB+3:MUX_LSB];
      end
    end

    // Phase detector tick and quarter-rate timer tick
    if (ref_edge_w) begin
      if (s_q.pdiv >= pdiv_last_w) begin
        s_d.pdiv = 5'h0;
        s_d.phase_detector  = 1'b1;
      end else begin
        s_d.pdiv = s_q.pdiv + 5'h1;
      end
    end
    if (s_q.phase_detector) begin
      s_d.qdiv = s_q.qdiv + 2'h1;
      if (s_q.qdiv == TICK_DIV_LAST) begin
        s_d.qtick = 1'b1;
      end
    end

    // Hop start after a frequency word write
    if (freq_wr_w) begin
      if (s_q.mode == MODE_LD_10NS) begin
        s_d.hop      = 1'b1;
        s_d.hop_wait = 1'b0;
      end else begin
        s_d.hop_wait = 1'b1;
        s_d.hop_cnt  = HOP_DELAY_PFD;
      end
    end else if (s_q.hop_wait && s_q.phase_detector) begin
      if (s_q.hop_cnt == 5'h1) begin
        s_d.hop_wait = 1'b0;
        s_d.hop      = 1'b1;
      end
      s_d.hop_cnt = s_q.hop_cnt - 5'h1;
    end

    // Pump current boost and ramp-down
    if (s_q.hop) begin
      s_d.pump = PUMP_BOOST;
      s_d.ramp = 1'b0;
    end else begin
      if (texp_w[0]) begin
        s_d.ramp = 1'b1;
      end
      if (s_q.ramp && s_q.qtick) begin
        if (s_q.pump == PUMP_NOMINAL) begin
          s_d.ramp = 1'b0;
        end else begin
          s_d.pump = s_q.pump - 3'h1;
        end
      end
    end

    // Diagnostic output selection
    if (s_q.mux == MUX_LOCK) begin
      s_d.diag = s_q.flt[6] && !pd_pump_w;
    end else if (s_q.mux == MUX_REF_DIV) begin
      s_d.diag = s_q.flt[4];
    end else if (s_q.mux == MUX_INT_DIV) begin
      s_d.diag = s_q.flt[5];
    end else if (s_q.mux == MUX_PUMP_TMR) begin
      s_d.diag = tact_w[0];
    end else if (s_q.mux == MUX_SW12_TMR) begin
      s_d.diag = tact_w[2];
    end else if (s_q.mux == MUX_SW3_TMR) begin
      s_d.diag = tact_w[1];
    end else begin
      s_d.diag = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q      <= '0;
      s_q.rcnt <= 4'h1;
      s_q.pd   <= PD_RESET;
      s_q.mode <= MODE_DEFAULT;
      s_q.mux  <= MUX_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign loop_switch_one_o   = tact_w[2];
  assign loop_switch_two_o   = tact_w[2];
  assign loop_switch_three_o = tact_w[1];
  assign pump_current_exp_o  = s_q.pump;
  assign pump_hiz_o          = pd_hiz_w
                               | pd_pump_w;
  assign amp_power_down_o    = pd_amp_hi_w
                               & pd_amp_lo_w;
  assign dividers_hold_o     = pd_cnt_rst_w
                               | pd_pump_w;
  assign lock_detect_reset_o = pd_pump_w;
  assign ref_buffer_off_o    = pd_pump_w;
  assign dither_en_o         = (s_q.mode == MODE_DITHER);
  assign lock_thresh_10ns_o  = (s_q.mode == MODE_LD_10NS);
  assign pfd_tick_o          = s_q.phase_detector;
  assign hop_start_o         = s_q.hop;
  assign diagnostic_output_pin_o = s_q.diag;

endmodule

// >>> sfl_pkg.sv
// Constants for the fast-lock, power-down and diagnostic control block.
// Assumes 24-bit serial words with the three select bits in bits 2 to 0.
package sfl_pkg;

  // ----------------------------------------------------------------------
  // Serial word and register selection
  // ----------------------------------------------------------------------
  localparam int          WORD_W         = 24;
  localparam logic [2:0]  SEL_FREQ_WORD  = 3'h0;
  localparam logic [2:0]  SEL_DIV_SETUP  = 3'h1;
  localparam logic [2:0]  SEL_FASTLOCK   = 3'h4;
  localparam logic [2:0]  SEL_POWER_DOWN = 3'h5;
  localparam logic [2:0]  SEL_DIAG_MODES = 3'h6;

  // ----------------------------------------------------------------------
  // Fast-lock timer register fields
  // ----------------------------------------------------------------------
  localparam int          TMO_W          = 9;
  localparam int          TMO_LSB        = 5;
  localparam int          TSEL_LSB       = 3;
  localparam logic [1:0]  TSEL_SW12      = 2'h0;
  localparam logic [1:0]  TSEL_SW3       = 2'h1;
  localparam logic [1:0]  TSEL_PUMP      = 2'h2;
  localparam logic [1:0]  TICK_DIV_LAST  = 2'h3;

  // ----------------------------------------------------------------------
  // Divider setup register fields
  // ----------------------------------------------------------------------
  localparam int          DBL_BIT        = 23;
  localparam int          RCNT_LSB       = 18;
  localparam int          HALF_BIT       = 17;

  // ----------------------------------------------------------------------
  // Power-down register fields
  // ----------------------------------------------------------------------
  localparam int          AMP_PD_HI_BIT  = 7;
  localparam int          AMP_PD_LO_BIT  = 6;
  localparam int          CP_PD_BIT      = 5;
  localparam int          CNT_RST_BIT    = 4;
  localparam int          CP_HIZ_BIT     = 3;
  localparam logic [4:0]  PD_RESET       = 5'h1f;

  // ----------------------------------------------------------------------
  // Diagnostic and mode register fields
  // ----------------------------------------------------------------------
  localparam int          MODE_LSB       = 12;
  localparam int          MUX_LSB        = 3;
  localparam logic [3:0]  MODE_DEFAULT   = 4'h0;
  localparam logic [3:0]  MODE_DITHER    = 4'h3;
  localparam logic [3:0]  MODE_LD_10NS   = 4'h9;
  localparam logic [3:0]  MUX_LOW        = 4'h0;
  localparam logic [3:0]  MUX_LOCK       = 4'h1;
  localparam logic [3:0]  MUX_REF_DIV    = 4'h2;
  localparam logic [3:0]  MUX_INT_DIV    = 4'h3;
  localparam logic [3:0]  MUX_PUMP_TMR   = 4'h4;
  localparam logic [3:0]  MUX_SW12_TMR   = 4'h5;
  localparam logic [3:0]  MUX_SW3_TMR    = 4'h6;
  localparam logic [3:0]  MUX_RESET      = 4'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam logic [4:0]  HOP_DELAY_PFD  = 5'h10;
  localparam logic [2:0]  PUMP_BOOST     = 3'h6;
  localparam logic [2:0]  PUMP_NOMINAL   = 3'h0;
  localparam int          SYNC_N         = 7;

endpackage

// >>> sfl_timeout.sv
// One fast-lock timeout counter.
// Assumes tick_i is a one-cycle pulse at a quarter of the phase detector rate.
`timescale 1ns/100ps
module sfl_timeout
  import sfl_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Programming and control
  input  wire logic             load_i,
  input  wire logic [TMO_W-1:0] count_i,
  input  wire logic             start_i,
  input  wire logic             tick_i,
  // Status
  output logic                  active_o,
  output logic                  expired_o
);

  typedef struct packed {
    logic [TMO_W-1:0] cfg;
    logic [TMO_W-1:0] cnt;
    logic             run;
    logic             exp;
  } sfl_tmo_state_t;

  sfl_tmo_state_t s_q;
  sfl_tmo_state_t s_d;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.exp = 1'b0;
    if (load_i) begin
      s_d.cfg = count_i;
    end
    if (start_i) begin
      s_d.cnt = s_q.cfg;
      s_d.run = (s_q.cfg != '0);
    end else if (s_q.run && tick_i) begin
      if (s_q.cnt == TMO_W'(1)) begin
        s_d.run = 1'b0;
        s_d.exp = 1'b1;
      end
      s_d.cnt = s_q.cnt - TMO_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active_o  = s_q.run;
  assign expired_o = s_q.exp;

endmodule

// >>> sfl_ctrl_chk.sv
// Concurrent checks on the outputs of the control block.
// Assumes it is bound into sfl_ctrl and sees only its ports.
`timescale 1ns/100ps
module sfl_ctrl_chk
  import sfl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Switches and pump
  input  wire logic       loop_switch_one_o,
  input  wire logic       loop_switch_two_o,
  input  wire logic       loop_switch_three_o,
  input  wire logic [2:0] pump_current_exp_o,
  input  wire logic       pump_hiz_o,
  // Power-down and modes
  input  wire logic       dividers_hold_o,
  input  wire logic       lock_detect_reset_o,
  input  wire logic       ref_buffer_off_o,
  input  wire logic       dither_en_o,
  input  wire logic       lock_thresh_10ns_o,
  // Events
  input  wire logic       pfd_tick_o,
  input  wire logic       hop_start_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_pd_pair;
    ref_buffer_off_o == lock_detect_reset_o;
  endproperty
  a_pd_pair: assert property (p_pd_pair)
    else $error("pump pd outputs split");

  property p_pd_hold;
    ref_buffer_off_o |-> pump_hiz_o && dividers_hold_o;
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("pump pd without hold");

  property p_sw_pair;
    loop_switch_one_o == loop_switch_two_o;
  endproperty
  a_sw_pair: assert property (p_sw_pair)
    else $error("switch one and two differ");

  property p_sw_rise;
    $rose(loop_switch_one_o || loop_switch_three_o)
      |-> $past(hop_start_o) || $past(hop_start_o, 2);
  endproperty
  a_sw_rise: assert property (p_sw_rise)
    else $error("switch closed without hop");

  property p_hop_pulse;
    hop_start_o |=> !hop_start_o;
  endproperty
  a_hop_pulse: assert property (p_hop_pulse)
    else $error("hop pulse too long");

  property p_pfd_pulse;
    pfd_tick_o |=> !pfd_tick_o;
  endproperty
  a_pfd_pulse: assert property (p_pfd_pulse)
    else $error("pfd pulse too long");

  property p_ramp_step;
    $changed(pump_current_exp_o) |-> pump_current_exp_o == PUMP_BOOST
      || pump_current_exp_o == $past(pump_current_exp_o) - 3'h1;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("pump step not a halving");

  property p_ramp_gap;
    pump_current_exp_o < $past(pump_current_exp_o)
      |=> $stable(pump_current_exp_o) [*8];
  endproperty
  a_ramp_gap: assert property (p_ramp_gap)
    else $error("pump steps too close");

  property p_mode_excl;
    !(dither_en_o && lock_thresh_10ns_o);
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("two modes at once");
endmodule

// >>> sfl_host.sv
// Host model loading 24-bit words over the serial pins.
// Assumes the block oversamples the pins with its own clock.
`timescale 1ns/100ps
module sfl_host (
  // Serial pins
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end

  // MSB first, clock idles low, data inverted after the frame
  task automatic send(input logic [23:0] w);
    #20;
    for (int i = 23; i >= 0; i--) begin
      ser_data_o = w[i];
      #80 ser_clk_o = 1'b1;
      #80 ser_clk_o = 1'b0;
    end
    #80 load_strobe_o = 1'b1;
    #80 load_strobe_o = 1'b0;
    ser_data_o = ~ser_data_o;
  endtask
endmodule

// >>> sfl_ctrl_tb.sv
// Bench for sfl_ctrl: register rows, then timer, hop and reset cases.
// Assumes sfl_host drives the serial pins; the checker is bound below.
`timescale 1ns/100ps
module sfl_ctrl_tb
  import sfl_pkg::*;
;
  logic        clk_i, nrst_i, ser_clk_i, ser_data_i, load_strobe_i;
  logic        ref_in_i, ref_div_i, int_div_i, lock_detect_i;
  logic        loop_switch_one_o, loop_switch_two_o, loop_switch_three_o;
  logic [2:0]  pump_current_exp_o;
  logic        pump_hiz_o, amp_power_down_o, dividers_hold_o;
  logic        lock_detect_reset_o, ref_buffer_off_o, dither_en_o;
  logic        lock_thresh_10ns_o, pfd_tick_o, hop_start_o;
  logic        diagnostic_output_pin_o;
  logic [7:0]  st;
  int          compares = 0;
  int          bad_count = 0;
  int          n, p, g, t;
  // Word, then amp hold ldr off hiz dither th10 diag
  logic [31:0] rows [10] = '{
    32'h000085_01,
    32'h0000cd_89,
    32'h000025_78,
    32'h000015_41,
    32'h000005_01,
    32'h00308e_05,
    32'h009096_03,
    32'h00009e_00,
    32'hfffff7_00,
    32'h00008e_01};

  assign st = {amp_power_down_o, dividers_hold_o, lock_detect_reset_o,
               ref_buffer_off_o, pump_hiz_o, dither_en_o,
               lock_thresh_10ns_o, diagnostic_output_pin_o};

  sfl_ctrl u_sfl_ctrl (
    .clk_i, .nrst_i, .ser_clk_i, .ser_data_i, .load_strobe_i, .ref_in_i,
    .ref_div_i, .int_div_i, .lock_detect_i, .loop_switch_one_o,
    .loop_switch_two_o, .loop_switch_three_o, .pump_current_exp_o,
    .pump_hiz_o, .amp_power_down_o, .dividers_hold_o,
    .lock_detect_reset_o, .ref_buffer_off_o, .dither_en_o,
    .lock_thresh_10ns_o, .pfd_tick_o, .hop_start_o,
    .diagnostic_output_pin_o
  );

  sfl_host u_sfl_host (
    .ser_clk_o     (ser_clk_i),
    .ser_data_o    (ser_data_i),
    .load_strobe_o (load_strobe_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    ref_in_i = 1'b0;
    forever #80 ref_in_i = ~ref_in_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic rst_chk();
    nrst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(st === 8'hf8 && pump_current_exp_o === 3'h0 &&
        loop_switch_three_o === 1'b0, "reset values");
  endtask

  task automatic gap();
    g = 0;
    @(posedge pfd_tick_o);
    @(negedge clk_i);
    do begin
      @(negedge clk_i);
      g++;
    end while (pfd_tick_o !== 1'b1 && g < 100);
  endtask

  task automatic div(input logic [23:0] w, input int e);
    u_sfl_host.send(w);
    repeat (40) @(negedge clk_i);
    gap();
    chk(g == e, "pfd spacing");
  endtask

  // Frequency word; clocks and pfd ticks from strobe to hop
  task automatic freq();
    n = 0;
    p = 0;
    fork
      u_sfl_host.send(24'h480140);
      begin
        @(posedge load_strobe_i);
        while (hop_start_o !== 1'b1 && n < 3000) begin
          @(negedge clk_i);
          n++;
          if (pfd_tick_o === 1'b1)
            p++;
        end
      end
    join
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_div_i = 1'b1;
    int_div_i = 1'b0;
    lock_detect_i = 1'b1;
    rst_chk();
    div(24'h080001, 16);
    div(24'h840001, 4);
    div(24'h060001, 16);
    div(24'h040001, 8);
    u_sfl_host.send(24'h0000d2);
    u_sfl_host.send(24'h480140);
    foreach (rows[i]) begin
      u_sfl_host.send(rows[i][31:8]);
      repeat (10) @(negedge clk_i);
      chk(st === rows[i][7:0], "register row");
    end
    // Diagnostic pin follows each selected monitor level
    lock_detect_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk(diagnostic_output_pin_o === 1'b0, "lock level");
    lock_detect_i = 1'b1;
    ref_div_i = 1'b0;
    u_sfl_host.send(24'h000096);
    repeat (10) @(negedge clk_i);
    chk(diagnostic_output_pin_o === 1'b0, "ref div level");
    int_div_i = 1'b1;
    u_sfl_host.send(24'h00009e);
    repeat (10) @(negedge clk_i);
    chk(diagnostic_output_pin_o === 1'b1, "int div level");
    u_sfl_host.send(24'h0090b6);
    u_sfl_host.send(24'h004284);
    u_sfl_host.send(24'h00428c);
    u_sfl_host.send(24'h0041b4);
    u_sfl_host.send(24'h00401c);
    freq();
    chk(n <= 8, "hop not immediate");
    repeat (3) @(negedge clk_i);
    chk({loop_switch_one_o, loop_switch_two_o, loop_switch_three_o,
         diagnostic_output_pin_o} === 4'hf &&
        pump_current_exp_o === PUMP_BOOST, "boost start");
    repeat (50) @(negedge clk_i);
    freq();
    chk(loop_switch_three_o === 1'b1, "switch open at restart");
    t = 0;
    while (loop_switch_three_o === 1'b1 && t < 500) begin
      @(negedge clk_i);
      if (pfd_tick_o === 1'b1)
        t++;
    end
    chk(t >= 76 && t <= 80, "switch span");
    repeat (3) @(negedge clk_i);
    chk(loop_switch_one_o === 1'b0 && diagnostic_output_pin_o === 1'b0 &&
        pump_current_exp_o === PUMP_NOMINAL, "ramp end");
    u_sfl_host.send(24'h00008e);
    freq();
    chk(p >= 16 && p <= 17, "hop wait");
    repeat (20) @(negedge clk_i);
    rst_chk();
    test_done();
  end

  initial begin
    #400000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    test_done();
  end
endmodule

bind sfl_ctrl sfl_ctrl_chk u_sfl_ctrl_chk (
  .clk_i, .nrst_i, .loop_switch_one_o, .loop_switch_two_o,
  .loop_switch_three_o, .pump_current_exp_o, .pump_hiz_o,
  .dividers_hold_o, .lock_detect_reset_o, .ref_buffer_off_o,
  .dither_en_o, .lock_thresh_10ns_o, .pfd_tick_o, .hop_start_o
);
